// ===== design/lsd_defines.vh
/*
 * Field layout, encodings and reset values of the unpacked system segment
 * descriptor registers and of the legacy flags application register.
 * Assumes inclusion by bare name.
 */
`ifndef LSD_DEFINES_VH
`define LSD_DEFINES_VH

// ------------------------------------------------------------
// Descriptor field positions
// ------------------------------------------------------------
`define LSD_BASE_HI      31
`define LSD_BASE_LO      0
`define LSD_LIM_HI       51
`define LSD_LIM_LO       32
`define LSD_TYPE_HI      55
`define LSD_TYPE_LO      52
`define LSD_CLASS_BIT    56
`define LSD_DPL_HI       58
`define LSD_DPL_LO       57
`define LSD_PRES_BIT     59
`define LSD_SPARE_HI     62
`define LSD_SPARE_LO     60
`define LSD_GRAN_BIT     63
`define LSD_GRAN_SHIFT   12
`define LSD_GRAN_FILL    12'hfff

// ------------------------------------------------------------
// Descriptor select codes
// ------------------------------------------------------------
`define LSD_SEL_LDT      2'h0
`define LSD_SEL_GDT      2'h1
`define LSD_SEL_TSS      2'h2
`define LSD_SEL_IDT      2'h3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define LSD_DESC_RST     64'h0000_0000_0000_0000
`define LSD_FLAGS_RST    32'h0000_0002

// ------------------------------------------------------------
// Legacy flags register layout
// ------------------------------------------------------------
`define LSD_FLAGS_RSVD   32'hffc0_8028
`define LSD_FLAGS_ONE    32'h0000_0002
`define LSD_FLAGS_NT     14

`endif

// ===== design/lsd_regs.v
/*
 * System segment descriptor register file (local table, global table and
 * task state descriptors) with legacy-mode reference checks, port bitmap
 * gating and legacy flags register write checks.
 * Assumes all inputs synchronous to mclk; the core pipeline supplies
 * decoded requests as one-cycle strobes and consumes check results one
 * cycle later.
 * Assumes the pipeline offers at most one reference per cycle and turns
 * the registered fault flags into its own exceptions.
 * Assumes the interrupt table select code is never meant to hold state.
 * Assumes software keeps the spare field at zero for future use.
 */
`timescale 1ns/1ps
`include "lsd_defines.vh"

module lsd_regs #(
  parameter NDESC = 3
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        arst_n,
  // Native direct descriptor access
  input  wire        nat_wr,
  input  wire [1:0]  nat_sel,
  input  wire [63:0] nat_wdata,
  input  wire        nat_rd,
  output reg  [63:0] nat_rdata_q,
  // Legacy packed descriptor load
  input  wire        leg_load,
  input  wire [1:0]  leg_sel,
  input  wire [63:0] leg_packed,
  // Legacy memory reference check
  input  wire        ref_req,
  input  wire        ref_legacy,
  input  wire [1:0]  ref_sel,
  input  wire [31:0] ref_offset,
  input  wire [1:0]  current_privilege_level,
  input  wire [1:0]  stack_segment_privilege,
  output reg  [63:0] ref_start_q,
  output reg         ref_grant_q,
  output reg         general_protection_fault_q,
  output reg         limit_fault_q,
  // Port permission gating
  input  wire        io_check_control,
  input  wire        io_req,
  output reg         io_bitmap_check_q,
  output reg  [31:0] io_bitmap_base_q,
  // Legacy flags register
  input  wire        flags_nat_wr,
  input  wire [31:0] flags_wdata,
  input  wire        flags_leg_wr,
  output reg  [31:0] legacy_flags_register_q,
  output reg         rsvd_field_fault_q,
  output reg         nested_task_intercept_q
);

  // ------------------------------------------------------------
  // Descriptor storage
  // ------------------------------------------------------------
  reg  [63:0] desc_q [0:NDESC-1];
  reg  [63:0] unpacked;
  reg  [63:0] sel_desc;
  reg  [31:0] eff_limit;
  wire        stack_priv_unused;

  // Fields of the descriptor picked by a reference
  wire [31:0] ref_base;
  wire [19:0] ref_lim;
  wire [1:0]  ref_dpl;
  wire        ref_present;
  wire        ref_gran;

  // Check terms of a reference
  wire        ref_checked;
  wire        ref_native;
  wire        lim_ok;
  wire        priv_ok;

  // Flags write decode and next value
  wire        flags_rsvd_hit;
  wire        flags_nt_change;
  wire        flags_nat_take;
  wire        flags_leg_take;
  reg  [31:0] legacy_flags_register_d;

  // Stack privilege is user-writable, so it is deliberately ignored
  assign stack_priv_unused = |stack_segment_privilege;

  // Packed table layout to register layout; spare bits forced to zero
  always @* begin
    unpacked = 64'h0;
    // Base in three pieces
    unpacked[15:0]  = leg_packed[31:16];
    unpacked[23:16] = leg_packed[39:32];
    unpacked[31:24] = leg_packed[63:56];
    // Limit in two pieces
    unpacked[47:32] = leg_packed[15:0];
    unpacked[51:48] = leg_packed[51:48];
    // Attributes; type and class are kept for the consuming pipeline
    unpacked[`LSD_TYPE_HI:`LSD_TYPE_LO] = leg_packed[43:40];
    unpacked[`LSD_CLASS_BIT] = leg_packed[44];
    unpacked[`LSD_DPL_HI:`LSD_DPL_LO] = leg_packed[46:45];
    unpacked[`LSD_PRES_BIT] = leg_packed[47];
    unpacked[`LSD_GRAN_BIT] = leg_packed[55];
  end

  // One entry per descriptor; the interrupt table code selects nothing
  genvar gi;
  generate
    for (gi = 0; gi < NDESC; gi = gi + 1) begin : g_desc
      always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          desc_q[gi] <= `LSD_DESC_RST;
        end else if (leg_load && {30'h0, leg_sel} == gi) begin
          // A legacy load wins over a native write to the same entry
          desc_q[gi] <= unpacked;
        end else if (nat_wr && {30'h0, nat_sel} == gi) begin
          // Stored as given, no field checks, no privilege gate
          desc_q[gi] <= nat_wdata;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Reference check
  // ------------------------------------------------------------
  // Select descriptor; the interrupt table code reads as all zero
  always @* begin
    sel_desc = 64'h0;
    if (ref_sel != `LSD_SEL_IDT) begin
      sel_desc = desc_q[ref_sel];
    end
  end

  // Byte or page granular limit; page form opens the low twelve bits
  always @* begin
    if (ref_gran) begin
      eff_limit = {ref_lim, `LSD_GRAN_FILL};
    end else begin
      eff_limit = {12'h000, ref_lim};
    end
  end

  // ------------------------------------------------------------
  // Field extraction and check terms
  // ------------------------------------------------------------
  // Spare field is never looked at, whatever software left in it
  assign ref_base    = sel_desc[`LSD_BASE_HI:`LSD_BASE_LO];
  assign ref_lim     = sel_desc[`LSD_LIM_HI:`LSD_LIM_LO];
  assign ref_dpl     = sel_desc[`LSD_DPL_HI:`LSD_DPL_LO];
  assign ref_present = sel_desc[`LSD_PRES_BIT];
  assign ref_gran    = sel_desc[`LSD_GRAN_BIT];

  // A legacy reference to the interrupt table code gets no checks
  assign ref_checked = ref_req && ref_legacy && (ref_sel != `LSD_SEL_IDT);
  assign ref_native  = ref_req && !ref_legacy;
  assign lim_ok      = (ref_offset <= eff_limit);
  // Stack privilege is user-writable, so only the secured level counts
  assign priv_ok     = (current_privilege_level <= ref_dpl);

  // ------------------------------------------------------------
  // Reference results
  // ------------------------------------------------------------
  // Segment start, zero-extended from the 32-bit base
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ref_start_q <= 64'h0;
    end else if (ref_checked) begin
      ref_start_q <= {32'h0, ref_base};
    end else begin
      // Base is ignored for native references
      ref_start_q <= 64'h0;
    end
  end

  // Absent segment faults regardless of limit or privilege
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      general_protection_fault_q <= 1'b0;
    end else begin
      general_protection_fault_q <= ref_checked && !ref_present;
    end
  end

  // Limit fault is reported beside the protection fault, not instead
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      limit_fault_q <= 1'b0;
    end else begin
      limit_fault_q <= ref_checked && !lim_ok;
    end
  end

  // Grant needs presence, limit and privilege together
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ref_grant_q <= 1'b0;
    end else if (ref_checked) begin
      ref_grant_q <= ref_present && lim_ok && priv_ok;
    end else begin
      // Native references pass without any check
      ref_grant_q <= ref_native;
    end
  end

  // ------------------------------------------------------------
  // Native read and port bitmap gating
  // ------------------------------------------------------------
  // Read data holds until the next read strobe
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      nat_rdata_q <= 64'h0;
    end else if (nat_rd) begin
      nat_rdata_q <= (nat_sel == `LSD_SEL_IDT) ? 64'h0 : desc_q[nat_sel];
    end
  end

  // Bitmap check only when enabled; task state never drives task switches
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      io_bitmap_check_q <= 1'b0;
    end else begin
      io_bitmap_check_q <= io_req && io_check_control;
    end
  end

  // Bitmap base tracks the task state entry every cycle
  // Only the base is used; the rest of the entry is opaque here
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      io_bitmap_base_q <= 32'h0;
    end else begin
      io_bitmap_base_q <= desc_q[`LSD_SEL_TSS][`LSD_BASE_HI:`LSD_BASE_LO];
    end
  end

  // ------------------------------------------------------------
  // Legacy flags register
  // ------------------------------------------------------------
  // Write decode; a native write with a reserved bit set is dropped
  assign flags_rsvd_hit  = |(flags_wdata & `LSD_FLAGS_RSVD);
  assign flags_nt_change = flags_wdata[`LSD_FLAGS_NT] != legacy_flags_register_q[`LSD_FLAGS_NT];
  assign flags_nat_take  = flags_nat_wr && !flags_rsvd_hit;
  assign flags_leg_take  = flags_leg_wr && !flags_nt_change;

  // Next value; an accepted native write wins over a legacy write in the same cycle
  always @* begin
    legacy_flags_register_d = legacy_flags_register_q;
    if (flags_nat_take) begin
      // Bit one always reads one
      legacy_flags_register_d = flags_wdata | `LSD_FLAGS_ONE;
    end else if (flags_leg_take) begin
      // Reserved bits read zero whoever writes them
      legacy_flags_register_d = (flags_wdata & ~`LSD_FLAGS_RSVD) | `LSD_FLAGS_ONE;
    end
  end

  // Held purely as state; no native logic reads it
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      legacy_flags_register_q <= `LSD_FLAGS_RST;
    end else begin
      legacy_flags_register_q <= legacy_flags_register_d;
    end
  end

  // Field fault pulses one cycle per offending native write
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rsvd_field_fault_q <= 1'b0;
    end else begin
      rsvd_field_fault_q <= flags_nat_wr && flags_rsvd_hit;
    end
  end

  // Intercept hands a legacy write's nested task change to the native system
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      nested_task_intercept_q <= 1'b0;
    end else begin
      nested_task_intercept_q <= flags_leg_wr && flags_nt_change;
    end
  end

endmodule // lsd_regs

// ===== verif/lsd_regs_props.sv
/*
 * Port-level checker for the segment descriptor register file.
 * Assumes binding to lsd_regs; every input mirrors a top-level port.
 */
`timescale 1ns/1ps
`include "lsd_defines.vh"
module lsd_regs_props (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        arst_n,
  // Requests
  input wire logic        ref_req,
  input wire logic        ref_legacy,
  input wire logic [1:0]  ref_sel,
  input wire logic        io_req,
  input wire logic        io_check_control,
  input wire logic        flags_nat_wr,
  input wire logic        flags_leg_wr,
  input wire logic [31:0] flags_wdata,
  // Results
  input wire logic        io_bitmap_check_q,
  input wire logic        ref_grant_q,
  input wire logic        general_protection_fault_q,
  input wire logic        limit_fault_q,
  input wire logic        rsvd_field_fault_q,
  input wire logic        nested_task_intercept_q,
  input wire logic [63:0] ref_start_q,
  input wire logic [31:0] legacy_flags_register_q
);
  // ----------------------------------------
  // Relations between requests and results
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_io_gate: assert property (io_req |=> io_bitmap_check_q == $past(io_check_control))
    else $error("port bitmap check does not follow its control bit");
  a_io_idle: assert property (!io_req |=> !io_bitmap_check_q)
    else $error("port bitmap check without a port request");
  a_gpf_cause: assert property (general_protection_fault_q |-> $past(ref_req && ref_legacy))
    else $error("protection fault without a legacy reference");
  a_native_ref: assert property (ref_req && !ref_legacy && ref_sel != 2'h3 |=>
    ref_grant_q && !general_protection_fault_q && !limit_fault_q && ref_start_q == 64'h0)
    else $error("native reference was checked or given a start");
  a_start_zext: assert property (ref_start_q[63:32] == 32'h0 &&
    (ref_start_q == 64'h0 || $past(ref_req && ref_legacy && ref_sel != 2'h3)))
    else $error("segment start not zero extended or not from a legacy reference");
  a_grant_excl: assert property (ref_grant_q |-> !general_protection_fault_q && !limit_fault_q)
    else $error("grant together with a fault");
  a_rsvd_fault: assert property (flags_nat_wr && !flags_leg_wr &&
    (flags_wdata & `LSD_FLAGS_RSVD) != 32'h0 |=>
    rsvd_field_fault_q && $stable(legacy_flags_register_q))
    else $error("reserved flag write not faulted or not dropped");
  a_rsvd_cause: assert property (rsvd_field_fault_q |-> $past(flags_nat_wr))
    else $error("field fault without a native flags write");
  a_nt_trap: assert property (flags_leg_wr && !flags_nat_wr &&
    flags_wdata[14] != legacy_flags_register_q[14] |=>
    nested_task_intercept_q && $stable(legacy_flags_register_q))
    else $error("nested task change not intercepted");
endmodule // lsd_regs_props
bind lsd_regs lsd_regs_props u_lsd_regs_props (.*);

// ===== verif/test_lsd_regs.sv
/*
 * Self-checking bench for lsd_regs: drivers queue expectations, a watcher
 * compares them one cycle later. Assumes the design answers with latency 1.
 */
`timescale 1ns/1ps
`include "lsd_defines.vh"
module test_lsd_regs;
  // ----------------------------------------
  // Signals and bench state
  // ----------------------------------------
  logic mclk = 0, arst_n = 0, nat_wr = 0, nat_rd = 0, leg_load = 0, ref_req = 0, ref_legacy = 0;
  logic io_check_control = 0, io_req = 0, flags_nat_wr = 0, flags_leg_wr = 0, pend = 0;
  logic [1:0]  nat_sel = 0, leg_sel = 0, ref_sel = 0, current_privilege_level = 0;
  logic [1:0]  stack_segment_privilege = 0;
  logic [63:0] nat_wdata = 0, leg_packed = 0, nat_rdata_q, ref_start_q, d, mem [0:3];
  logic [31:0] ref_offset = 0, flags_wdata = 0, io_bitmap_base_q, legacy_flags_register_q;
  logic [31:0] el, v, fl;
  logic        ref_grant_q, general_protection_fault_q, limit_fault_q, io_bitmap_check_q;
  logic        rsvd_field_fault_q, nested_task_intercept_q, lf, ft, nt;
  logic [65:0] q [$];
  int n_mismatch = 0, checked = 0, seed = 4, i;
  lsd_regs u_lsd_regs (.*);
  always #12.5 mclk = ~mclk;
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Packed table descriptor to register layout, spare field zero
  function automatic logic [63:0] unpk(input logic [63:0] p);
    return {p[55], 3'h0, p[47], p[46:45], p[44], p[43:40], p[51:48], p[15:0], p[63:56],
            p[39:32], p[31:16]};
  endfunction
  // One strobe vector per edge; never cleared and set in one time step
  task automatic op(input logic [1:0] k, input logic [63:0] e, input logic [6:0] s);
    if (s[4:0] != 0) q.push_back({k, e});
    {nat_wr, leg_load, nat_rd, ref_req, io_req, flags_nat_wr, flags_leg_wr} = s;
    @(posedge mclk);
    #1;
  endtask
  // Watcher: negedge sees the results of the previous edge settled
  always @(negedge mclk) begin
    if (pend) begin
      case (q[0][65:64])
        2'h0: chk(nat_rdata_q, q[0][63:0]);
        2'h1: chk({ref_start_q[31:0], 29'h0, ref_grant_q, general_protection_fault_q,
                   limit_fault_q}, q[0][63:0]);
        2'h2: chk({io_bitmap_base_q, 31'h0, io_bitmap_check_q}, q[0][63:0]);
        default: chk({rsvd_field_fault_q, nested_task_intercept_q, 30'h0,
                      legacy_flags_register_q}, q[0][63:0]);
      endcase
      void'(q.pop_front());
    end
    pend = nat_rd | ref_req | io_req | flags_nat_wr | flags_leg_wr;
  end
  initial begin
    #20000;
    n_mismatch++;
    close_out;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    #1 arst_n = 1;
    op(0, 64'h0, 7'h10);
    for (i = 0; i < 4; i++) begin
      d = {$random(seed), $random(seed)};
      nat_sel = i[1:0];
      nat_wdata = d;
      mem[i] = (i == 3) ? 64'h0 : d;
      op(0, 0, 7'h40);
      op(0, mem[i], 7'h10);
    end
    d = {$random(seed), $random(seed)};
    leg_sel = 1;
    leg_packed = d;
    nat_sel = 1;
    op(0, 0, 7'h20);
    op(0, unpk(d), 7'h10);
    nat_sel = 2;
    ref_sel = 2;
    ref_legacy = 1;
    for (i = 0; i < 12; i++) begin
      d = {$random(seed), $random(seed)};
      nat_wdata = d;
      el = d[63] ? {d[51:32], 12'hfff} : {12'h0, d[51:32]};
      ref_offset = el + i % 3 - 1;
      current_privilege_level = 2'($random(seed));
      stack_segment_privilege = ~current_privilege_level;
      lf = ref_offset > el;
      op(0, 0, 7'h40);
      op(1, {d[31:0], 29'h0, d[59] && !lf && current_privilege_level <= d[58:57], !d[59], lf},
         7'h08);
      io_check_control = i[0];
      op(2, {d[31:0], 31'h0, io_check_control}, 7'h04);
    end
    ref_legacy = 0;
    op(1, 64'h4, 7'h08);
    ref_legacy = 1;
    ref_sel = 3;
    op(1, 64'h0, 7'h08);
    d = {$random(seed), $random(seed)};
    leg_sel = 0;
    nat_sel = 0;
    leg_packed = d;
    nat_wdata = ~d;
    op(0, 0, 7'h60);
    op(0, unpk(d), 7'h10);
    fl = `LSD_FLAGS_RST;
    for (i = 0; i < 9; i++) begin
      v = $random(seed);
      flags_wdata = (i % 3 == 0) ? v : v & ~`LSD_FLAGS_RSVD;
      ft = (i % 3 == 0) && (v & `LSD_FLAGS_RSVD) != 0;
      nt = (i % 3 == 2) && flags_wdata[14] != fl[14];
      if (!ft && !nt) fl = flags_wdata | `LSD_FLAGS_ONE;
      op(3, {ft, nt, 30'h0, fl}, (i % 3 == 2) ? 7'h01 : 7'h02);
    end
    op(0, 0, 7'h00);
    repeat (3) @(posedge mclk);
    close_out;
  end
endmodule // test_lsd_regs
